/* vdh_map.vh */
`ifndef VDH_MAP_VH
`define VDH_MAP_VH

// Register subaddresses
`define VDH_ADDR_IRQB_CLEAR    8'h1C
`define VDH_ADDR_IRQB_MASK     8'h1D
`define VDH_ADDR_IRQB_CONFIG   8'h1E
`define VDH_ADDR_INPUT_SEL2    8'h20
`define VDH_ADDR_REF_CLK_SEL   8'h21
`define VDH_ADDR_STD_SELECT    8'h28
`define VDH_ADDR_CPU_LAUNCH    8'h7F
`define VDH_ADDR_FW_MAJOR_REV  8'h80
`define VDH_ADDR_LOCK_STATUS1  8'h81
`define VDH_ADDR_IRQB_STATUS   8'h85
`define VDH_ADDR_IRQB_ACTIVE   8'h86

// Interrupt B source positions
`define VDH_IRQB_SW_INIT       7
`define VDH_IRQB_CP_CHANGED    6
`define VDH_IRQB_CMD_READY     5
`define VDH_IRQB_FIELD_RATE    4
`define VDH_IRQB_LINE_ALT      3
`define VDH_IRQB_COLOR_LOCK    2
`define VDH_IRQB_HV_LOCK       1
`define VDH_IRQB_TV_VCR        0

// Field positions
`define VDH_CFG_POLARITY_BIT   0
`define VDH_SEL_DECIM_BIT      4
`define VDH_SEL_CHROMA_BIT     1
`define VDH_SEL_LUMA_BIT       0
`define VDH_XTAL_BIT           0
`define VDH_STD_MSB            3
`define VDH_STD_LSB            0
`define VDH_ACT_BIT            0
`define VDH_ST1_PEAK_WHITE     7
`define VDH_ST1_LINE_ALT       6
`define VDH_ST1_FIELD_RATE     5
`define VDH_ST1_LOST_LOCK      4
`define VDH_ST1_COLOR_LOCK     3
`define VDH_ST1_VSYNC_LOCK     2
`define VDH_ST1_HSYNC_LOCK     1
`define VDH_ST1_TV_VCR         0

// Reset values
`define VDH_RST_BYTE           8'h00
`define VDH_RST_NIBBLE         4'h0
`define VDH_RST_BIT            1'b0
`define VDH_STD_AUTO           4'h0

`endif

/* vdh_evt_bit.v */
`include "vdh_map.vh"
`default_nettype none

module vdh_evt_bit #(
  parameter W      = 1,
  parameter CHANGE = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] cond,
  input  wire         clr,
  output wire         flag
);

  reg [W-1:0] prev_ff;
  reg         armed_ff;
  reg         flag_ff;
  wire        hit;
  wire        nxt_flag;

  // First cycle after reset only samples, so a static level is no event
  assign hit = armed_ff &&
               ((CHANGE != 0) ? (cond != prev_ff) : (|(cond & ~prev_ff)));
  assign nxt_flag = hit | (flag_ff & ~clr);
  assign flag = flag_ff;

  always @(posedge clk) begin
    if (rst) begin
      prev_ff  <= {W{`VDH_RST_BIT}};
      armed_ff <= `VDH_RST_BIT;
      flag_ff  <= `VDH_RST_BIT;
    end else begin
      prev_ff  <= cond;
      armed_ff <= 1'b1;
      flag_ff  <= nxt_flag;
    end
  end

endmodule // vdh_evt_bit

`default_nettype wire

/* vdh_irq_pin.v */
`default_nettype none

module vdh_irq_pin (
  input  wire active,
  input  wire active_high,
  output wire pin_o,
  output wire pin_oe
);

  // Pin is only ever pulled low; released state is high-impedance
  assign pin_o  = 1'b0;
  assign pin_oe = active_high ? ~active : active;

endmodule // vdh_irq_pin

`default_nettype wire

/* vdh_irq_regs.v */
// Overview of operation
// - Writing 1 to an interrupt-B clear bit clears that status bit unless its source fires in the same cycle; 0 leaves it.
// - Eight interrupt-B sources share one fixed bit position across clear, mask, status.
// - Mask bit 1 lets its source drive the pin, 0 blocks; masks reset 0.
// - Masking gates only the pin and the active register; status bits still set.
// - Pin asserts exactly when any status bit and its mask bit are both set.
// - Config bit 0 picks pin polarity: 0 active low (reset), 1 active high.
// - Active low: pull pin low when active, release when inactive.
// - Active high: release pin when active, pull low when inactive.
// - Input select bits 1/0 route chroma/luma to first or second converter.
// - Decimation select 0 keeps filter in path (reset), 1 bypasses it.
// - Reference clock bit 0: 0 is 14.31818 MHz (reset), 1 is 27 MHz.
// - Standard code low nibble: 0 automatic (reset), 1..12 force standards.
// - Nonzero standard code forces that standard even while autoswitching runs.
// - Any write to the launch register starts the embedded processor.
// - Major firmware revision register is read-only and returns the ROM revision.
// - Status one bit 4 latches lost lock since last read of that register.
// - Status one bits 7,6,5: peak white, line alternation, field rate 50 Hz.
// - Status one bits 3..1 colour, vertical, horizontal lock; bit 0 VCR source.
// - Interrupt-B status latches each condition until host clears it.
// - Active register bit 0 reads 1 while any status bit and its mask bit are both set.
`include "vdh_map.vh"
`default_nettype none

module vdh_irq_regs #(
  parameter [7:0] FW_MAJOR_REV = 8'h01
) (
  input  wire       REF_CLK,
  input  wire       RST,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_WR,
  input  wire       REG_RD,
  output reg  [7:0] REG_RDATA,
  output reg        REG_RVALID,
  input  wire       SW_INIT_READY,
  input  wire [1:0] CP_DETECT,
  input  wire       CMD_READY,
  input  wire       PEAK_WHITE,
  input  wire       LINE_ALT,
  input  wire       FIELD_50HZ,
  input  wire       COLOR_LOCK,
  input  wire       VSYNC_LOCK,
  input  wire       HSYNC_LOCK,
  input  wire       VCR_SOURCE,
  output wire       INTB_O,
  output wire       INTB_OE,
  output reg        CHROMA_SECOND_CONV,
  output reg        LUMA_SECOND_CONV,
  output reg        DECIM_BYPASS,
  output reg        REF_CLK_27MHZ,
  output reg  [3:0] STD_CODE,
  output reg        STD_FORCED,
  output reg        CPU_START,
  output reg        CPU_RUNNING
);

  reg  [7:0] mask_ff;
  reg        polarity_ff;
  reg  [7:0] nxt_rdata;
  reg        lost_lock_ff;
  reg  [2:0] lock_prev_ff;
  reg        lock_armed_ff;
  reg        wr_clear;
  reg        wr_mask;
  reg        wr_config;
  reg        wr_sel;
  reg        wr_xtal;
  reg        wr_std;
  reg        wr_launch;
  wire       rd_status1;
  wire [7:0] clr_vec;
  wire [7:0] irq_status;
  wire       irq_active;
  wire [2:0] lock_now;
  wire       lock_lost;
  wire       nxt_lost_lock;
  wire [7:0] status1;

  // One write strobe per writable register; writes elsewhere are dropped
  always @* begin
    wr_clear  = 1'b0;
    wr_mask   = 1'b0;
    wr_config = 1'b0;
    wr_sel    = 1'b0;
    wr_xtal   = 1'b0;
    wr_std    = 1'b0;
    wr_launch = 1'b0;
    case (REG_ADDR)
      `VDH_ADDR_IRQB_CLEAR: begin
        wr_clear = REG_WR;
      end
      `VDH_ADDR_IRQB_MASK: begin
        wr_mask = REG_WR;
      end
      `VDH_ADDR_IRQB_CONFIG: begin
        wr_config = REG_WR;
      end
      `VDH_ADDR_INPUT_SEL2: begin
        wr_sel = REG_WR;
      end
      `VDH_ADDR_REF_CLK_SEL: begin
        wr_xtal = REG_WR;
      end
      `VDH_ADDR_STD_SELECT: begin
        wr_std = REG_WR;
      end
      `VDH_ADDR_CPU_LAUNCH: begin
        wr_launch = REG_WR;
      end
      default: begin
        wr_clear = 1'b0;
      end
    endcase
  end

  assign rd_status1 = REG_RD && (REG_ADDR == `VDH_ADDR_LOCK_STATUS1);

  assign clr_vec = wr_clear ? REG_WDATA : `VDH_RST_BYTE;

  // Interrupt B sources, one position each
  vdh_evt_bit #(.W(1), .CHANGE(0)) u_evt_sw_init (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (SW_INIT_READY),
    .clr  (clr_vec[`VDH_IRQB_SW_INIT]),
    .flag (irq_status[`VDH_IRQB_SW_INIT])
  );

  vdh_evt_bit #(.W(2), .CHANGE(1)) u_evt_cp (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (CP_DETECT),
    .clr  (clr_vec[`VDH_IRQB_CP_CHANGED]),
    .flag (irq_status[`VDH_IRQB_CP_CHANGED])
  );

  vdh_evt_bit #(.W(1), .CHANGE(0)) u_evt_cmd (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (CMD_READY),
    .clr  (clr_vec[`VDH_IRQB_CMD_READY]),
    .flag (irq_status[`VDH_IRQB_CMD_READY])
  );

  vdh_evt_bit #(.W(1), .CHANGE(1)) u_evt_field (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (FIELD_50HZ),
    .clr  (clr_vec[`VDH_IRQB_FIELD_RATE]),
    .flag (irq_status[`VDH_IRQB_FIELD_RATE])
  );

  vdh_evt_bit #(.W(1), .CHANGE(1)) u_evt_line (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (LINE_ALT),
    .clr  (clr_vec[`VDH_IRQB_LINE_ALT]),
    .flag (irq_status[`VDH_IRQB_LINE_ALT])
  );

  vdh_evt_bit #(.W(1), .CHANGE(1)) u_evt_color (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (COLOR_LOCK),
    .clr  (clr_vec[`VDH_IRQB_COLOR_LOCK]),
    .flag (irq_status[`VDH_IRQB_COLOR_LOCK])
  );

  vdh_evt_bit #(.W(2), .CHANGE(1)) u_evt_hv (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond ({HSYNC_LOCK, VSYNC_LOCK}),
    .clr  (clr_vec[`VDH_IRQB_HV_LOCK]),
    .flag (irq_status[`VDH_IRQB_HV_LOCK])
  );

  vdh_evt_bit #(.W(1), .CHANGE(1)) u_evt_vcr (
    .clk  (REF_CLK),
    .rst  (RST),
    .cond (VCR_SOURCE),
    .clr  (clr_vec[`VDH_IRQB_TV_VCR]),
    .flag (irq_status[`VDH_IRQB_TV_VCR])
  );

  // Mask only reaches the pin and the active register; status bits are set regardless
  assign irq_active = |(irq_status & mask_ff);

  vdh_irq_pin u_pin (
    .active      (irq_active),
    .active_high (polarity_ff),
    .pin_o       (INTB_O),
    .pin_oe      (INTB_OE)
  );

  // Lost lock: any of the three locks falling
  assign lock_now  = {COLOR_LOCK, VSYNC_LOCK, HSYNC_LOCK};
  assign lock_lost = lock_armed_ff && (|(lock_prev_ff & ~lock_now));
  // A loss in the reading cycle survives the read-clear
  assign nxt_lost_lock = lock_lost | (lost_lock_ff & ~rd_status1);

  assign status1 = {PEAK_WHITE, LINE_ALT, FIELD_50HZ, lost_lock_ff,
                    COLOR_LOCK, VSYNC_LOCK, HSYNC_LOCK, VCR_SOURCE};

  always @(posedge REF_CLK) begin
    if (RST) begin
      lost_lock_ff  <= `VDH_RST_BIT;
      lock_prev_ff  <= {3{`VDH_RST_BIT}};
      lock_armed_ff <= `VDH_RST_BIT;
    end else begin
      lost_lock_ff  <= nxt_lost_lock;
      lock_prev_ff  <= lock_now;
      lock_armed_ff <= 1'b1;
    end
  end

  // Launch pulse and sticky running flag
  always @(posedge REF_CLK) begin
    if (RST) begin
      CPU_START   <= `VDH_RST_BIT;
      CPU_RUNNING <= `VDH_RST_BIT;
    end else begin
      CPU_START <= wr_launch;
      if (wr_launch) begin
        CPU_RUNNING <= 1'b1;
      end
    end
  end

  // Interrupt mask and pin polarity
  always @(posedge REF_CLK) begin
    if (RST) begin
      mask_ff     <= `VDH_RST_BYTE;
      polarity_ff <= `VDH_RST_BIT;
    end else begin
      if (wr_mask) begin
        mask_ff <= REG_WDATA;
      end
      if (wr_config) begin
        polarity_ff <= REG_WDATA[`VDH_CFG_POLARITY_BIT];
      end
    end
  end

  // Converter routing, decimation and reference clock select
  always @(posedge REF_CLK) begin
    if (RST) begin
      CHROMA_SECOND_CONV <= `VDH_RST_BIT;
      LUMA_SECOND_CONV   <= `VDH_RST_BIT;
      DECIM_BYPASS       <= `VDH_RST_BIT;
      REF_CLK_27MHZ      <= `VDH_RST_BIT;
    end else begin
      if (wr_sel) begin
        CHROMA_SECOND_CONV <= REG_WDATA[`VDH_SEL_CHROMA_BIT];
        LUMA_SECOND_CONV   <= REG_WDATA[`VDH_SEL_LUMA_BIT];
        DECIM_BYPASS       <= REG_WDATA[`VDH_SEL_DECIM_BIT];
      end
      if (wr_xtal) begin
        REF_CLK_27MHZ <= REG_WDATA[`VDH_XTAL_BIT];
      end
    end
  end

  // Video standard code
  always @(posedge REF_CLK) begin
    if (RST) begin
      STD_CODE   <= `VDH_STD_AUTO;
      STD_FORCED <= `VDH_RST_BIT;
    end else begin
      if (wr_std) begin
        STD_CODE   <= REG_WDATA[`VDH_STD_MSB:`VDH_STD_LSB];
        // Nonzero code overrides the autoswitch firmware
        STD_FORCED <= |REG_WDATA[`VDH_STD_MSB:`VDH_STD_LSB];
      end
    end
  end

  // Read mux; write-only and unmapped addresses read zero
  always @* begin
    nxt_rdata = `VDH_RST_BYTE;
    case (REG_ADDR)
      `VDH_ADDR_IRQB_MASK: begin
        nxt_rdata = mask_ff;
      end
      `VDH_ADDR_IRQB_CONFIG: begin
        nxt_rdata[`VDH_CFG_POLARITY_BIT] = polarity_ff;
      end
      `VDH_ADDR_INPUT_SEL2: begin
        nxt_rdata[`VDH_SEL_DECIM_BIT]  = DECIM_BYPASS;
        nxt_rdata[`VDH_SEL_CHROMA_BIT] = CHROMA_SECOND_CONV;
        nxt_rdata[`VDH_SEL_LUMA_BIT]   = LUMA_SECOND_CONV;
      end
      `VDH_ADDR_REF_CLK_SEL: begin
        nxt_rdata[`VDH_XTAL_BIT] = REF_CLK_27MHZ;
      end
      `VDH_ADDR_STD_SELECT: begin
        nxt_rdata[`VDH_STD_MSB:`VDH_STD_LSB] = STD_CODE;
      end
      `VDH_ADDR_FW_MAJOR_REV: begin
        nxt_rdata = FW_MAJOR_REV;
      end
      `VDH_ADDR_LOCK_STATUS1: begin
        nxt_rdata = status1;
      end
      `VDH_ADDR_IRQB_STATUS: begin
        nxt_rdata = irq_status;
      end
      `VDH_ADDR_IRQB_ACTIVE: begin
        nxt_rdata[`VDH_ACT_BIT] = irq_active;
      end
      `VDH_ADDR_IRQB_CLEAR: begin
        nxt_rdata = `VDH_RST_BYTE;
      end
      `VDH_ADDR_CPU_LAUNCH: begin
        nxt_rdata = `VDH_RST_BYTE;
      end
      default: begin
        nxt_rdata = `VDH_RST_BYTE;
      end
    endcase
  end

  // Valid pulses once per read
  always @(posedge REF_CLK) begin
    if (RST) begin
      REG_RVALID <= `VDH_RST_BIT;
    end else begin
      REG_RVALID <= REG_RD;
    end
  end

  // Read data holds until the next read
  always @(posedge REF_CLK) begin
    if (RST) begin
      REG_RDATA <= `VDH_RST_BYTE;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= nxt_rdata;
      end
    end
  end

endmodule // vdh_irq_regs

`default_nettype wire

/* vdh_irq_regs_checker.sv */
`default_nettype none
module vdh_irq_regs_checker (
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       INTB_OE,
  input wire logic       CHROMA_SECOND_CONV,
  input wire logic       LUMA_SECOND_CONV,
  input wire logic       DECIM_BYPASS,
  input wire logic       REF_CLK_27MHZ,
  input wire logic [3:0] STD_CODE,
  input wire logic       STD_FORCED,
  input wire logic       CPU_START,
  input wire logic       CPU_RUNNING
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_std;
  logic wr_sel;
  logic wr_xtl;
  logic wr_go;
  assign wr_std = REG_WR && REG_ADDR == 8'h28;
  assign wr_sel = REG_WR && REG_ADDR == 8'h20;
  assign wr_xtl = REG_WR && REG_ADDR == 8'h21;
  assign wr_go  = REG_WR && REG_ADDR == 8'h7F;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_launch_pulse: assert property (wr_go |=> CPU_START && CPU_RUNNING)
    else $error("launch write gave no start");
  chk_launch_cause: assert property (CPU_START |-> $past(wr_go))
    else $error("start without launch write");
  chk_run_sticky: assert property ($rose(CPU_RUNNING) |=> CPU_RUNNING [*8])
    else $error("running flag dropped");
  chk_std_write: assert property (wr_std |=> STD_CODE == $past(REG_WDATA[3:0])
    && STD_FORCED == ($past(REG_WDATA[3:0]) != 4'h0))
    else $error("standard code not taken");
  chk_std_stable: assert property (!wr_std |=> $stable(STD_CODE))
    else $error("standard code moved");
  chk_input_route: assert property (wr_sel |=> {DECIM_BYPASS, CHROMA_SECOND_CONV,
    LUMA_SECOND_CONV} == {$past(REG_WDATA[4]), $past(REG_WDATA[1:0])})
    else $error("input routing not taken");
  chk_clock_sel: assert property (wr_xtl |=> REF_CLK_27MHZ == $past(REG_WDATA[0]))
    else $error("clock select not taken");
  chk_reset_vals: assert property ($past(RST) |-> STD_CODE == 4'h0 && !(INTB_OE
    || DECIM_BYPASS || REF_CLK_27MHZ || CPU_RUNNING || STD_FORCED))
    else $error("output not at reset value");
  cov_launch: cover property (wr_go ##1 CPU_START);
  cov_pin: cover property ($rose(INTB_OE));
  cov_forced: cover property (wr_std ##1 STD_FORCED);
endmodule // vdh_irq_regs_checker

bind vdh_irq_regs vdh_irq_regs_checker u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .INTB_OE(INTB_OE),
  .CHROMA_SECOND_CONV(CHROMA_SECOND_CONV), .LUMA_SECOND_CONV(LUMA_SECOND_CONV),
  .DECIM_BYPASS(DECIM_BYPASS), .REF_CLK_27MHZ(REF_CLK_27MHZ), .STD_CODE(STD_CODE),
  .STD_FORCED(STD_FORCED), .CPU_START(CPU_START), .CPU_RUNNING(CPU_RUNNING));
`default_nettype wire

/* vdh_host_model.sv */
`default_nettype none
module vdh_host_model (
  input  wire logic       REF_CLK,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID,
  output var  logic [7:0] REG_ADDR,
  output var  logic [7:0] REG_WDATA,
  output var  logic       REG_WR,
  output var  logic       REG_RD
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pol_a = 1'b0;
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  // Released lines flip so a stale address or data is never reused
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge REF_CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = dt;
    REG_WR = 1'b1;
    @(posedge REF_CLK);
    #1;
    REG_WR = 1'b0;
    REG_ADDR = ~REG_ADDR;
    REG_WDATA = ~REG_WDATA;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dt, output logic vl);
    @(posedge REF_CLK);
    #1;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge REF_CLK);
    #1;
    dt = REG_RDATA;
    vl = REG_RVALID;
    REG_RD = 1'b0;
    REG_ADDR = ~REG_ADDR;
  endtask
  // Interrupt B pin polarity is recorded and written to the config register
  task automatic set_pol(input logic p);
    pol_a = p;
    wr(8'h1E, {7'h00, pol_a});
  endtask
endmodule // vdh_host_model
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary revision value
  localparam logic [7:0]  REV = 8'h3C;
  localparam logic [10:0] SRC [8] = '{11'h001, 11'h002, 11'h008, 11'h010,
                                      11'h020, 11'h040, 11'h080, 11'h200};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] cv = 11'h000;
  logic [7:0]  addr, wdata, rdata, d, e, m;
  logic        wr, rd, rvalid, v, io, oe, chr, lum, dec, x27, go, run, frc;
  logic [3:0]  std;
  int          seed = 32'h65d5;
  int          bad_count = 0;
  int          total_checks = 0;
  always #2 ref_clk = ~ref_clk;
  vdh_host_model u_host (.REF_CLK(ref_clk), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd));
  vdh_irq_regs #(.FW_MAJOR_REV(REV)) u_dut (.REF_CLK(ref_clk), .RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SW_INIT_READY(cv[9]), .CP_DETECT(cv[8:7]), .CMD_READY(cv[6]),
    .PEAK_WHITE(cv[10]), .LINE_ALT(cv[4]), .FIELD_50HZ(cv[5]), .COLOR_LOCK(cv[3]),
    .VSYNC_LOCK(cv[2]), .HSYNC_LOCK(cv[1]), .VCR_SOURCE(cv[0]), .INTB_O(io),
    .INTB_OE(oe), .CHROMA_SECOND_CONV(chr), .LUMA_SECOND_CONV(lum), .DECIM_BYPASS(dec),
    .REF_CLK_27MHZ(x27), .STD_CODE(std), .STD_FORCED(frc), .CPU_START(go),
    .CPU_RUNNING(run));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] x);
    u_host.rd(a, d, v);
    chk("rvalid", {7'h00, v}, 8'h01);
    chk(n, d, x);
  endtask
  function automatic logic [7:0] st1(input logic lost);
    return {cv[10], cv[4], cv[5], lost, cv[3], cv[2], cv[1], cv[0]};
  endfunction
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk("pins", {io, oe, chr, lum, dec, x27, go, run}, 8'h00);
    rchk("mask", 8'h1D, 8'h00);
    rchk("cfg", 8'h1E, 8'h00);
    rchk("sel", 8'h20, 8'h00);
    rchk("xtal", 8'h21, 8'h00);
    rchk("std", 8'h28, 8'h00);
    u_host.wr(8'h80, 8'hFF);
    rchk("rev", 8'h80, REV);
    rchk("clr rd", 8'h1C, 8'h00);
    rchk("unmapped", 8'h55, 8'h00);
    for (int c = 0; c < 13; c++) begin
      e = $random(seed);
      u_host.wr(8'h28, {e[7:4], c[3:0]});
      chk("code", {frc, 3'h0, std}, {(c != 0), 3'h0, c[3:0]});
      u_host.wr(8'h20, e);
      chk("route", {5'h00, dec, chr, lum}, {5'h00, e[4], e[1:0]});
      rchk("sel rd", 8'h20, e & 8'h13);
      u_host.wr(8'h21, e);
      chk("xtal", {7'h00, x27}, {7'h00, e[0]});
      u_host.wr(8'h1D, e);
      rchk("mask rd", 8'h1D, e);
    end
    rchk("std rd", 8'h28, 8'h0C);
    u_host.wr(8'h7F, e);
    chk("launch", {6'h00, go, run}, 8'h03);
    @(posedge ref_clk);
    #1;
    chk("launched", {6'h00, go, run}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      u_host.wr(8'h1D, i[0] ? 8'h00 : m);
      cv = cv ^ SRC[i];
      @(posedge ref_clk);
      #1;
      chk("set pin", {7'h00, oe}, {7'h00, !i[0]});
      rchk("status", 8'h85, m);
      u_host.wr(8'h1D, ~m);
      chk("other mask", {7'h00, oe}, 8'h00);
      u_host.wr(8'h1D, m);
      chk("pin lo", {7'h00, oe}, 8'h01);
      rchk("active", 8'h86, 8'h01);
      u_host.set_pol(1'b1);
      chk("pin hi", {7'h00, oe}, 8'h00);
      u_host.wr(8'h1C, ~m);
      rchk("kept", 8'h85, m);
      u_host.wr(8'h1C, m);
      chk("pin idle", {7'h00, oe}, 8'h01);
      rchk("cleared", 8'h85, 8'h00);
      rchk("inactive", 8'h86, 8'h00);
      u_host.set_pol(1'b0);
      u_host.wr(8'h1D, 8'h00);
    end
    // Clear and a fresh change land on one edge
    fork
      u_host.wr(8'h1C, 8'h01);
      begin
        @(posedge ref_clk);
        #1;
        cv[0] = ~cv[0];
      end
    join
    rchk("set wins", 8'h85, 8'h01);
    cv[10] = $random(seed);
    rchk("st1", 8'h81, st1(1'b0));
    cv[1] = 1'b0;
    rchk("st1 lost", 8'h81, st1(1'b1));
    rchk("st1 again", 8'h81, st1(1'b0));
    close_out();
  end
endmodule // tb_top
`default_nettype wire
